// File: design/dio_pkg.sv
package dio_pkg;

    // ----------------------------------------------------------------
    // channel counts and widths
    // ----------------------------------------------------------------
    localparam int NUM_IN   = 6;            // input channels
    localparam int NUM_OUT  = 6;            // output channels
    localparam int CNT_W    = 32;           // pulse counter width
    localparam int TIME_W   = 16;           // width of every time setting

    // ----------------------------------------------------------------
    // timebase
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;     // 10 MHz system clock
    localparam int TICK_NS       = 100000;  // fine tick, 0.1 ms
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int MS_NS         = 1000000; // coarse tick, 1 ms
    localparam int MS_TICKS      = MS_NS / TICK_NS;
    localparam int GATE_MS       = 1000;    // frequency gate, 1 s

    localparam logic [15:0] TICK_LAST  = 16'(TICK_CYC - 1);
    localparam logic [3:0]  MS_LAST    = 4'(MS_TICKS - 1);
    localparam logic [15:0] GATE_LAST  = 16'(GATE_MS - 1);

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0]  CNT_RST  = 32'h0000_0000;
    localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;

    // ----------------------------------------------------------------
    // input channel modes
    // ----------------------------------------------------------------
    localparam logic [2:0] IN_PLAIN   = 3'h0;   // plain level
    localparam logic [2:0] IN_COUNT   = 3'h1;   // pulse counter
    localparam logic [2:0] IN_LATCH_R = 3'h2;   // rising-edge latch
    localparam logic [2:0] IN_LATCH_F = 3'h3;   // falling-edge latch
    localparam logic [2:0] IN_FREQ    = 3'h4;   // frequency

    // ----------------------------------------------------------------
    // output channel modes
    // ----------------------------------------------------------------
    localparam logic [1:0] OUT_PLAIN  = 2'h0;   // follows command
    localparam logic [1:0] OUT_PULSE  = 2'h1;   // pulse generator
    localparam logic [1:0] OUT_DLY_ON = 2'h2;   // delayed turn-on
    localparam logic [1:0] OUT_DLY_OF = 2'h3;   // delayed turn-off

endpackage

// File: design/dio_channels.sv
`timescale 1ns/1ps

// Functional notes
// - host idle timeout drives outputs to fail-safe
// - fail-safe enabled channels forced high on timeout
// - peer idle timeout reports safety value
// - inversion complements level in plain/counter/latch
// - filter rejects pulses shorter than minimum widths
// - counter counts pulses while run bit set
// - clear command zeroes count register
// - retain option restores count after power-up
// - rising edge sets latch until cleared
// - falling edge sets latch until cleared
// - frequency mode measures input frequency
// - five input modes selectable
// - four output modes selectable
// - plain output follows host, readable back
// - pulse phases follow low/high widths
// - continuous or burst, start/stop controlled
// - burst stops after programmed pulse total
// - delayed turn-on delays rising change
// - delayed turn-off delays falling change
module dio_channels (
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    // input channels
    input  wire logic [dio_pkg::NUM_IN-1:0]       in_pin,
    input  wire logic [dio_pkg::NUM_IN-1:0][2:0]  in_mode,
    input  wire logic [dio_pkg::NUM_IN-1:0]       in_invert,
    input  wire logic [dio_pkg::NUM_IN-1:0]       filt_en,
    input  wire logic [dio_pkg::TIME_W-1:0]       filt_low_ms,
    input  wire logic [dio_pkg::TIME_W-1:0]       filt_high_ms,
    input  wire logic [dio_pkg::NUM_IN-1:0]       cnt_run,
    input  wire logic [dio_pkg::NUM_IN-1:0]       cnt_clear,
    input  wire logic [dio_pkg::NUM_IN-1:0]       cnt_retain,
    input  wire logic [dio_pkg::NUM_IN-1:0][31:0] cnt_saved,
    input  wire logic [dio_pkg::NUM_IN-1:0]       latch_clear,
    output logic      [dio_pkg::NUM_IN-1:0]       in_level,
    output logic      [dio_pkg::NUM_IN-1:0][31:0] cnt_value,
    output logic      [dio_pkg::NUM_IN-1:0]       latch_status,
    output logic      [dio_pkg::NUM_IN-1:0][15:0] freq_hz,
    // output channels
    input  wire logic [dio_pkg::NUM_OUT-1:0][1:0] out_mode,
    input  wire logic [dio_pkg::NUM_OUT-1:0]      out_cmd,
    input  wire logic [dio_pkg::NUM_OUT-1:0]      fail_safe_value,
    input  wire logic [dio_pkg::TIME_W-1:0]       pulse_low_w,
    input  wire logic [dio_pkg::TIME_W-1:0]       pulse_high_w,
    input  wire logic                             pulse_cont,
    input  wire logic [dio_pkg::TIME_W-1:0]       pulse_total,
    input  wire logic [dio_pkg::NUM_OUT-1:0]      pulse_start,
    input  wire logic [dio_pkg::NUM_OUT-1:0]      pulse_stop,
    input  wire logic [dio_pkg::TIME_W-1:0]       delay_time,
    output logic      [dio_pkg::NUM_OUT-1:0]      out_pin,
    output logic      [dio_pkg::NUM_OUT-1:0]      out_readback,
    output logic      [dio_pkg::NUM_OUT-1:0]      pulse_busy,
    // watchdogs
    input  wire logic                             host_pkt,
    input  wire logic [dio_pkg::TIME_W-1:0]       host_idle_ms,
    input  wire logic                             peer_wd_en,
    input  wire logic                             peer_pkt,
    input  wire logic [dio_pkg::TIME_W-1:0]       peer_idle_ms,
    output logic                                  comm_idle_trip,
    output logic                                  peer_safety_send,
    output logic      [dio_pkg::NUM_OUT-1:0]      peer_safety_value
);

    localparam int NI = dio_pkg::NUM_IN;
    localparam int NO = dio_pkg::NUM_OUT;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0]         pre;      // cycles within fine tick
        logic [3:0]          msc;      // fine ticks within a ms
        logic                tick;     // fine tick strobe
        logic                ms;       // ms strobe
        logic                booted;   // power-up restore done
        logic [NI-1:0]       filt;     // filtered raw level
        logic [NI-1:0][15:0] fcnt;     // filter width counter
        logic [NI-1:0]       lvl;      // level after inversion
        logic [NI-1:0]       prev;     // previous filtered level
        logic [NI-1:0][31:0] cnt;      // pulse counts
        logic [NI-1:0]       latch;    // latch flags
        logic [15:0]         gate;     // frequency gate ms
        logic [NI-1:0][15:0] edges;    // edges within gate
        logic [NI-1:0][15:0] freq;     // last frequency result
        logic [NO-1:0]       out;      // output pins
        logic [NO-1:0]       run;      // pulse generator active
        logic [NO-1:0]       phase;    // 1 = high phase
        logic [NO-1:0][15:0] pcnt;     // phase tick counter
        logic [NO-1:0][15:0] pdone;    // pulses emitted
        logic [NO-1:0][15:0] dcnt;     // delay tick counter
        logic [NO-1:0]       base;     // output before fail-safe
        logic [15:0]         hidle;    // host idle ms
        logic                htrip;    // host watchdog tripped
        logic [15:0]         pidle;    // peer idle ms
        logic                ptrip;    // peer watchdog tripped
        logic                psend;    // safety report strobe
        logic [NO-1:0]       pval;     // registered report value
    } dio_state_s;

    dio_state_s st_q;   // registered state
    dio_state_s st_d;   // next state

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic          raw;
        logic [15:0]   need;
        logic          rise;
        logic          fall;
        logic [15:0]   hw;
        logic [15:0]   lw;
        logic          want;
        logic          slow;
        raw  = 1'b0;
        need = 16'h0000;
        rise = 1'b0;
        fall = 1'b0;
        hw   = 16'h0000;
        lw   = 16'h0000;
        want = 1'b0;
        slow = 1'b0;
        st_d = st_q;

        // timebase: 0.1 ms tick and 1 ms tick from the clock
        st_d.tick = 1'b0;
        st_d.ms   = 1'b0;
        if (st_q.pre == dio_pkg::TICK_LAST) begin
            st_d.pre  = 16'h0000;
            st_d.tick = 1'b1;
            if (st_q.msc == dio_pkg::MS_LAST) begin
                st_d.msc = 4'h0;
                st_d.ms  = 1'b1;
            end else begin
                st_d.msc = st_q.msc + 4'h1;
            end
        end else begin
            st_d.pre = st_q.pre + 16'h0001;
        end

        // frequency gate: one second window
        if (st_q.ms) begin
            st_d.gate = (st_q.gate == dio_pkg::GATE_LAST) ? 16'h0000 : st_q.gate + 16'h0001;
        end

        // ------------------------------------------------------------
        // input channels
        // ------------------------------------------------------------
        for (int i = 0; i < NI; i++) begin
            raw = in_pin[i];
            // width filter in ms
            if (!filt_en[i] || raw == st_q.filt[i]) begin
                st_d.filt[i] = raw;
                st_d.fcnt[i] = 16'h0000;
            end else begin
                need = raw ? filt_high_ms : filt_low_ms;
                if (st_q.fcnt[i] >= need) begin
                    st_d.filt[i] = raw;
                    st_d.fcnt[i] = 16'h0000;
                end else if (st_q.ms) begin
                    st_d.fcnt[i] = st_q.fcnt[i] + 16'h0001;
                end
            end
            st_d.prev[i] = st_q.filt[i];
            // inversion applies except in frequency mode
            st_d.lvl[i] = st_q.filt[i] ^ (in_invert[i] && in_mode[i] != dio_pkg::IN_FREQ);
            rise = st_d.lvl[i] && !st_q.lvl[i];
            fall = !st_d.lvl[i] && st_q.lvl[i];

            // mode select
            case (in_mode[i])
                dio_pkg::IN_COUNT: begin
                    if (rise && cnt_run[i]) begin
                        st_d.cnt[i] = st_q.cnt[i] + 32'h0000_0001;
                    end
                end
                dio_pkg::IN_LATCH_R: begin
                    if (rise) begin
                        st_d.latch[i] = 1'b1;
                    end
                end
                dio_pkg::IN_LATCH_F: begin
                    if (fall) begin
                        st_d.latch[i] = 1'b1;
                    end
                end
                dio_pkg::IN_FREQ: begin
                    if (st_q.filt[i] && !st_q.prev[i]) begin
                        st_d.edges[i] = st_q.edges[i] + 16'h0001;
                    end
                end
                default: begin
                    // plain input: level only
                end
            endcase
            // gate end publishes rising edges per second
            if (st_q.ms && st_q.gate == dio_pkg::GATE_LAST) begin
                st_d.freq[i]  = st_q.edges[i];
                st_d.edges[i] = 16'h0000;
            end
            if (in_mode[i] != dio_pkg::IN_FREQ) begin
                st_d.edges[i] = 16'h0000;
            end
            // clears beat a same-cycle event
            if (cnt_clear[i]) begin
                st_d.cnt[i] = dio_pkg::CNT_RST;
            end
            if (latch_clear[i]) begin
                st_d.latch[i] = 1'b0;
            end
            // first cycle after reset: restore retained count
            if (!st_q.booted) begin
                st_d.cnt[i] = cnt_retain[i] ? cnt_saved[i] : dio_pkg::CNT_RST;
            end
        end
        st_d.booted = 1'b1;

        // ------------------------------------------------------------
        // output channels
        // ------------------------------------------------------------
        // zero widths act as one tick
        hw = (pulse_high_w == 16'h0000) ? 16'h0001 : pulse_high_w;
        lw = (pulse_low_w  == 16'h0000) ? 16'h0001 : pulse_low_w;
        for (int j = 0; j < NO; j++) begin
            // mode select
            case (out_mode[j])
                dio_pkg::OUT_PULSE: begin
                    st_d.dcnt[j] = 16'h0000;
                    if (pulse_stop[j]) begin
                        st_d.run[j]  = 1'b0;
                        st_d.base[j] = 1'b0;
                    end else if (pulse_start[j] && !st_q.run[j]) begin
                        st_d.run[j]   = 1'b1;
                        st_d.phase[j] = 1'b1;
                        st_d.base[j]  = 1'b1;
                        st_d.pcnt[j]  = 16'h0000;
                        st_d.pdone[j] = 16'h0000;
                    end else if (st_q.run[j] && st_q.tick) begin
                        if (st_q.phase[j] && st_q.pcnt[j] + 16'h0001 >= hw) begin
                            st_d.phase[j] = 1'b0;
                            st_d.base[j]  = 1'b0;
                            st_d.pcnt[j]  = 16'h0000;
                        end else if (!st_q.phase[j] && st_q.pcnt[j] + 16'h0001 >= lw) begin
                            st_d.pcnt[j]  = 16'h0000;
                            st_d.pdone[j] = st_q.pdone[j] + 16'h0001;
                            if (!pulse_cont && st_q.pdone[j] + 16'h0001 >= pulse_total) begin
                                st_d.run[j] = 1'b0;
                            end else begin
                                st_d.phase[j] = 1'b1;
                                st_d.base[j]  = 1'b1;
                            end
                        end else begin
                            st_d.pcnt[j] = st_q.pcnt[j] + 16'h0001;
                        end
                    end
                end
                dio_pkg::OUT_DLY_ON, dio_pkg::OUT_DLY_OF: begin
                    st_d.run[j] = 1'b0;
                    want = out_cmd[j];
                    slow = (out_mode[j] == dio_pkg::OUT_DLY_ON) ? want : !want;
                    if (want == st_q.base[j]) begin
                        st_d.dcnt[j] = 16'h0000;
                    end else if (!slow) begin
                        st_d.base[j] = want;                        // undelayed direction
                        st_d.dcnt[j] = 16'h0000;
                    end else if (st_q.dcnt[j] >= delay_time) begin
                        st_d.base[j] = want;
                        st_d.dcnt[j] = 16'h0000;
                    end else if (st_q.tick) begin
                        st_d.dcnt[j] = st_q.dcnt[j] + 16'h0001;
                    end
                end
                default: begin
                    st_d.run[j]  = 1'b0;
                    st_d.dcnt[j] = 16'h0000;
                    st_d.base[j] = out_cmd[j];
                end
            endcase
        end

        // ------------------------------------------------------------
        // communication watchdogs
        // ------------------------------------------------------------
        if (host_pkt) begin
            st_d.hidle = 16'h0000;
            st_d.htrip = 1'b0;
        // a full idle period must pass first
        end else if (host_idle_ms != 16'h0000 && st_q.hidle > host_idle_ms) begin
            st_d.htrip = 1'b1;
        end else if (st_q.ms) begin
            st_d.hidle = st_q.hidle + 16'h0001;
        end
        // fail-safe channels forced high while tripped
        st_d.out = st_d.htrip ? (st_d.base | fail_safe_value) : st_d.base;


        // peer report value held in a flop
        st_d.pval  = fail_safe_value;
        st_d.psend = 1'b0;
        if (!peer_wd_en || peer_pkt) begin
            st_d.pidle = 16'h0000;
            st_d.ptrip = 1'b0;
        // a full idle period must pass first
        end else if (peer_idle_ms != 16'h0000 && st_q.pidle > peer_idle_ms) begin
            st_d.ptrip = 1'b1;
            st_d.psend = !st_q.ptrip;
        end else if (st_q.ms) begin
            st_d.pidle = st_q.pidle + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from state flops
    // ----------------------------------------------------------------
    assign in_level          = st_q.lvl;
    assign cnt_value         = st_q.cnt;
    assign latch_status      = st_q.latch;
    assign freq_hz           = st_q.freq;
    assign out_pin           = st_q.out;
    assign out_readback      = st_q.out;
    assign pulse_busy        = st_q.run;
    assign comm_idle_trip    = st_q.htrip;
    assign peer_safety_send  = st_q.psend;
    // report value from its own flop
    assign peer_safety_value = st_q.pval;

endmodule

// File: verification/dio_channels_props.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// channel block checks
// ----------------------------------------------------------------
module dio_channels_props (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic [5:0][2:0]  in_mode,
    input wire logic [5:0]       cnt_run,
    input wire logic [5:0]       cnt_clear,
    input wire logic [5:0]       latch_clear,
    input wire logic [5:0][31:0] cnt_value,
    input wire logic [5:0]       latch_status,
    input wire logic [5:0][1:0]  out_mode,
    input wire logic [5:0]       out_cmd,
    input wire logic [5:0]       fail_safe_value,
    input wire logic [5:0]       pulse_start,
    input wire logic [5:0]       pulse_stop,
    input wire logic [5:0]       out_pin,
    input wire logic [5:0]       out_readback,
    input wire logic [5:0]       pulse_busy,
    input wire logic             host_pkt,
    input wire logic             comm_idle_trip,
    input wire logic [5:0]       peer_safety_value
);
    // checks idle during reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_plain_follow: assert property ($past(rst_n) && !comm_idle_trip
        && $past(out_mode[0]) == dio_pkg::OUT_PLAIN && !$past(comm_idle_trip)
        |-> out_pin[0] == $past(out_cmd[0])) else $error("plain out");
    a_readback_same: assert property (out_readback == out_pin)
        else $error("readback");
    a_fail_safe_high: assert property ((comm_idle_trip && fail_safe_value[0])[*2]
        |-> out_pin[0]) else $error("fail-safe");
    a_host_pkt_clear: assert property (host_pkt |=> !comm_idle_trip)
        else $error("trip kept");
    a_peer_value: assert property (peer_safety_value == $past(fail_safe_value))
        else $error("peer value");
    a_latch_hold: assert property (latch_status[1] && !latch_clear[1]
        && in_mode[1] == dio_pkg::IN_LATCH_R |=> latch_status[1]) else $error("latch lost");
    a_latch_clear: assert property (latch_clear[1] |=> !latch_status[1])
        else $error("latch kept");
    a_count_clear: assert property (cnt_clear[0] |=> cnt_value[0] == 32'h0000_0000)
        else $error("count kept");
    a_count_stop: assert property ((!cnt_run[0] && !cnt_clear[0])[*5]
        |=> $stable(cnt_value[0])) else $error("count moved");
    a_pulse_begin: assert property (pulse_start[3] && !pulse_stop[3] && !pulse_busy[3]
        && out_mode[3] == dio_pkg::OUT_PULSE |=> pulse_busy[3] && out_pin[3])
        else $error("no pulse");
    a_pulse_halt: assert property (pulse_stop[3] |=> !pulse_busy[3])
        else $error("still busy");
endmodule

bind dio_channels dio_channels_props props_u (
    .clock, .rst_n, .in_mode, .cnt_run, .cnt_clear, .latch_clear, .cnt_value,
    .latch_status, .out_mode, .out_cmd, .fail_safe_value, .pulse_start, .pulse_stop,
    .out_pin, .out_readback, .pulse_busy, .host_pkt, .comm_idle_trip, .peer_safety_value
);

// File: verification/dio_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host packet source
// ----------------------------------------------------------------
module dio_host_model #(
    parameter int GAP = 2000    // cycles between packets
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic active,   // link up
    output logic      host_pkt
);
    int gap_q;                  // cycles since last packet

    // first packet at once, none while inactive
    always_ff @(posedge clock) begin
        if (!rst_n || !active) begin
            gap_q    <= 0;
            host_pkt <= 1'b0;
        end else begin
            gap_q    <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
            host_pkt <= (gap_q == 0);
        end
    end
endmodule

// File: verification/test_dio_channels.sv
`timescale 1ns/1ps

module test_dio_channels;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic             clock, rst_n, host_on, host_pkt, pulse_cont, peer_wd_en, prev;
    logic             comm_idle_trip, peer_safety_send;
    logic [5:0]       in_pin, filt_en, in_invert, cnt_run, cnt_clear, cnt_retain, latch_clear;
    logic [5:0]       in_level, latch_status, out_cmd, fail_safe_value, pulse_start;
    logic [5:0]       pulse_stop, out_pin, out_readback, pulse_busy, peer_safety_value;
    logic [5:0][2:0]  in_mode;
    logic [5:0][1:0]  out_mode;
    logic [5:0][31:0] cnt_saved, cnt_value;
    logic [5:0][15:0] freq_hz;
    logic [15:0]      pulse_low_w, pulse_high_w, pulse_total, delay_time;
    logic [15:0]      host_idle_ms, peer_idle_ms;
    int               fails, checks, n, k, h;

    dio_channels dut_u (
        .clock, .rst_n, .in_pin, .in_mode, .in_invert, .filt_en,
        .filt_low_ms(16'h0001), .filt_high_ms(16'h0001), .cnt_run, .cnt_clear, .cnt_retain,
        .cnt_saved, .latch_clear, .in_level, .cnt_value, .latch_status, .freq_hz,
        .out_mode, .out_cmd, .fail_safe_value, .pulse_low_w, .pulse_high_w, .pulse_cont,
        .pulse_total, .pulse_start, .pulse_stop, .delay_time, .out_pin, .out_readback,
        .pulse_busy, .host_pkt, .host_idle_ms, .peer_wd_en, .peer_pkt(1'b0), .peer_idle_ms,
        .comm_idle_trip, .peer_safety_send, .peer_safety_value
    );

    dio_host_model #(.GAP(2000)) host_u (.clock, .rst_n, .active(host_on), .host_pkt);

    // 100 ns clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task step(input int c);
        repeat (c) @(posedge clock);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %0h", $time, what, got);
        end
    endtask

    task report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // high pulse on a pin
    task pin_pulse(input int ch);
        in_pin[ch] <= 1'b1;
        step(4);
        in_pin[ch] <= 1'b0;
        step(4);
    endtask

    // delayed mode check
    task dly(input int ch, input logic [1:0] mode, input logic from);
        out_mode[ch] <= mode;
        out_cmd[ch] <= from;
        step(3000);
        out_cmd[ch] <= ~from;
        step(5);
        @(negedge clock);
        chk(out_pin[ch], from, "early");
        for (n = 5; n < 4000 && out_pin[ch] !== ~from; n++) @(negedge clock);
        chk(n >= 1000 && n <= 2010, 1'b1, "delay");
        step(1);
        out_cmd[ch] <= from;
        step(3);
        @(negedge clock);
        chk(out_pin[ch], from, "back");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {in_pin, filt_en, in_invert, cnt_run, cnt_clear, latch_clear, out_cmd} = '0;
        {fail_safe_value, pulse_start, pulse_stop, in_mode, out_mode} = '0;
        {pulse_low_w, pulse_high_w, pulse_total, host_idle_ms, peer_idle_ms} = '0;
        {rst_n, host_on, pulse_cont, peer_wd_en, fails, checks} = '0;
        cnt_saved = '0;
        cnt_saved[0] = 32'h0000_0055;
        cnt_retain = 6'h01;
        delay_time = 16'h0002;
        step(10);
        rst_n <= 1'b1;
        step(3);
        @(negedge clock);
        chk(cnt_value[0], 32'h0000_0055, "retain");
        chk(cnt_value[1], 32'h0000_0000, "fresh");
        // plain in/out
        step(1);
        out_cmd <= 6'h2A;
        in_invert <= 6'h11;
        in_mode[4] <= dio_pkg::IN_FREQ;
        step(4);
        @(negedge clock);
        chk(out_pin, 6'h2A, "out");
        chk(out_readback, 6'h2A, "readback");
        chk(in_level, 6'h01, "invert");
        chk(freq_hz[4], 32'h0, "freq");
        $display("done plain");
        // counter
        step(1);
        {out_cmd, in_invert} <= '0;
        in_mode[0] <= dio_pkg::IN_COUNT;
        cnt_clear <= 6'h01;
        step(1);
        cnt_clear <= 6'h00;
        cnt_run <= 6'h01;
        step(1);
        repeat (3) pin_pulse(0);
        cnt_run <= 6'h00;
        pin_pulse(0);
        @(negedge clock);
        chk(cnt_value[0], 32'h0000_0003, "count");
        $display("done counter");
        // latches
        step(1);
        in_pin[2] <= 1'b1;
        step(4);
        in_mode[1] <= dio_pkg::IN_LATCH_R;
        in_mode[2] <= dio_pkg::IN_LATCH_F;
        step(4);
        {in_pin[2], in_pin[1]} <= 2'h1;
        step(6);
        {in_pin[2], in_pin[1]} <= 2'h2;
        step(6);
        @(negedge clock);
        chk(latch_status, 6'h06, "latched");
        step(1);
        latch_clear <= 6'h06;
        step(1);
        latch_clear <= 6'h00;
        @(negedge clock);
        chk(latch_status, 6'h00, "unlatch");
        $display("done latch");
        // pulse burst, then train
        step(1);
        out_mode[3] <= dio_pkg::OUT_PULSE;
        {pulse_low_w, pulse_high_w, pulse_total} <= {16'h0001, 16'h0001, 16'h0002};
        step(1);
        pulse_start <= 6'h08;
        step(1);
        pulse_start <= 6'h00;
        {k, h, prev} = '0;
        @(negedge clock);
        for (n = 0; n < 20000 && pulse_busy[3] === 1'b1; n++) begin
            k += int'(out_pin[3] && !prev);
            h += int'(out_pin[3]);
            prev = out_pin[3];
            @(negedge clock);
        end
        chk(k, 2, "pulses");
        chk(h >= 1000 && h <= 2001, 1'b1, "high");
        chk(out_pin[3], 1'b0, "end");
        step(1);
        pulse_cont <= 1'b1;
        pulse_start <= 6'h08;
        step(1);
        pulse_start <= 6'h00;
        step(6000);
        @(negedge clock);
        chk(pulse_busy[3], 1'b1, "runs");
        step(1);
        pulse_stop <= 6'h08;
        step(1);
        pulse_stop <= 6'h00;
        @(negedge clock);
        chk(pulse_busy[3], 1'b0, "stopped");
        $display("done pulse");
        step(1);
        dly(4, dio_pkg::OUT_DLY_ON, 1'b0);
        step(1);
        dly(5, dio_pkg::OUT_DLY_OF, 1'b1);
        $display("done delay");
        // watchdogs, channel 0 in the fail-safe mask
        step(1);
        host_on <= 1'b1;
        step(2);
        fail_safe_value <= 6'h01;
        host_idle_ms <= 16'h0001;
        step(12000);
        @(negedge clock);
        chk(comm_idle_trip, 1'b0, "no trip");
        step(1);
        host_on <= 1'b0;
        filt_en <= 6'h08;
        in_pin[3] <= 1'b1;
        step(2);
        @(negedge clock);
        chk(in_level[3], 1'b0, "glitch");
        for (n = 0; n < 40000 && comm_idle_trip !== 1'b1; n++) @(negedge clock);
        step(2);
        @(negedge clock);
        chk(comm_idle_trip, 1'b1, "trip");
        chk(in_level[3], 1'b1, "filtered");
        chk(out_pin[1:0], 2'h1, "safe");
        step(1);
        host_on <= 1'b1;
        for (n = 0; n < 3000 && comm_idle_trip !== 1'b0; n++) @(negedge clock);
        step(3);
        @(negedge clock);
        chk(out_pin[1:0], 2'h0, "cleared");
        step(1);
        peer_idle_ms <= 16'h0001;
        peer_wd_en <= 1'b1;
        for (n = 0; n < 40000 && peer_safety_send !== 1'b1; n++) @(negedge clock);
        chk(peer_safety_send, 1'b1, "peer");
        chk(peer_safety_value, 6'h01, "pval");
        $display("done watchdog");
        report_and_stop();
    end
endmodule
